// File: inc/bcm_consts.vh
/*
 Constants of the brushless commutator: register offsets, field positions and timing.
 Assumes inclusion by bare name from design files that share one byte-wide register port.
*/
`ifndef BCM_CONSTS_VH
`define BCM_CONSTS_VH
`define BCM_ADDR_FLAGS 8'h00
`define BCM_ADDR_STATUS 8'h07
`define BCM_ADDR_RING 8'h18
`define BCM_ADDR_RATE 8'h19
`define BCM_ADDR_LONE 8'h1A
`define BCM_ADDR_OVERLAP 8'h1B
`define BCM_ADDR_SHIFT 8'h1C
`define BCM_ADDR_POSITION 8'h1E
`define BCM_ADDR_CAP 8'h1F
`define BCM_BIT_HOLD 4
`define BCM_BIT_FOUR_PHASE 1
`define BCM_BIT_FULL_COUNT 2
`define BCM_RST_BYTE 8'h00
`define BCM_RING_MASK 8'h7F
`define BCM_PRESCALE 16
`define BCM_PRESCALE_LAST 4'hF
`endif

// File: verilog/bcm_commutator.v
/*
 Brushless commutator: encoder decode, circular ring counter, phase advance and phase enables.
 Assumes host register strobes on mclk, encoder pins asynchronous to mclk, rst_n async low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcm_consts.vh"
module bcm_commutator
(
  input wire mclk,
  input wire rst_n,
  input wire enc_a,
  input wire enc_b,
  input wire enc_index,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  output reg quad_step_ff,
  output reg quad_up_ff,
  output reg first_winding_drive,
  output reg second_winding_drive,
  output reg third_winding_drive,
  output reg fourth_winding_drive
);

  reg [7:0] flags_ff;
  reg [7:0] status_ff;
  reg [7:0] ring_length_ff;
  reg [7:0] advance_rate_timer_ff;
  reg [7:0] lone_phase_span_ff;
  reg [7:0] overlap_span_ff;
  reg [7:0] cycle_shift_ff;
  reg [7:0] advance_cap_ff;
  reg [2:0] a_sync_ff;
  reg [2:0] b_sync_ff;
  reg [2:0] idx_sync_ff;
  reg [2:0] settle_ff;
  reg [6:0] ring_cnt_ff;
  reg [3:0] presc_ff;
  reg [7:0] win_tmr_ff;
  reg [8:0] win_cnt_ff;
  reg [9:0] advance_ff;
  wire hold_commutator;
  wire four_phase;
  wire full_count;
  wire a_now;
  wire b_now;
  wire a_old;
  wire b_old;
  wire q_step;
  wire q_up;
  wire full_step;
  wire unit_step;
  wire index_rise;
  wire [6:0] ring;
  wire win_end;
  reg [6:0] nxt_ring_cnt;
  reg [8:0] nxt_win_cnt;
  reg [7:0] adv_mag;
  reg [9:0] ring10;
  reg [9:0] pos;
  reg [9:0] step10;
  reg [9:0] rem;
  reg [1:0] seg;
  reg [1:0] seg_next;
  reg ovl;
  reg [3:0] nxt_phase;

  assign hold_commutator = flags_ff[`BCM_BIT_HOLD];
  assign four_phase = status_ff[`BCM_BIT_FOUR_PHASE];
  assign full_count = status_ff[`BCM_BIT_FULL_COUNT];
  assign ring = ring_length_ff[6:0];

  // Register port; writes take effect at once so held shift writes step the phases
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_ff <= `BCM_RST_BYTE;
      status_ff <= `BCM_RST_BYTE;
      ring_length_ff <= `BCM_RST_BYTE;
      advance_rate_timer_ff <= `BCM_RST_BYTE;
      lone_phase_span_ff <= `BCM_RST_BYTE;
      overlap_span_ff <= `BCM_RST_BYTE;
      cycle_shift_ff <= `BCM_RST_BYTE;
      advance_cap_ff <= `BCM_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `BCM_ADDR_FLAGS)
        flags_ff <= reg_wdata;
      else if (reg_addr == `BCM_ADDR_STATUS)
        status_ff <= reg_wdata;
      else if (reg_addr == `BCM_ADDR_RING)
        ring_length_ff <= reg_wdata & `BCM_RING_MASK;
      else if (reg_addr == `BCM_ADDR_RATE)
        advance_rate_timer_ff <= reg_wdata;
      else if (reg_addr == `BCM_ADDR_LONE)
        lone_phase_span_ff <= reg_wdata & `BCM_RING_MASK;
      else if (reg_addr == `BCM_ADDR_OVERLAP)
        overlap_span_ff <= reg_wdata & `BCM_RING_MASK;
      else if (reg_addr == `BCM_ADDR_SHIFT)
        cycle_shift_ff <= reg_wdata;
      else if (reg_addr == `BCM_ADDR_CAP)
        advance_cap_ff <= reg_wdata & `BCM_RING_MASK;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= `BCM_RST_BYTE;
    else if (reg_rd)
    begin
      if (reg_addr == `BCM_ADDR_FLAGS)
        reg_rdata_ff <= flags_ff;
      else if (reg_addr == `BCM_ADDR_STATUS)
        reg_rdata_ff <= status_ff;
      else if (reg_addr == `BCM_ADDR_RING)
        reg_rdata_ff <= ring_length_ff;
      else if (reg_addr == `BCM_ADDR_RATE)
        reg_rdata_ff <= advance_rate_timer_ff;
      else if (reg_addr == `BCM_ADDR_LONE)
        reg_rdata_ff <= lone_phase_span_ff;
      else if (reg_addr == `BCM_ADDR_OVERLAP)
        reg_rdata_ff <= overlap_span_ff;
      else if (reg_addr == `BCM_ADDR_SHIFT)
        reg_rdata_ff <= cycle_shift_ff;
      else if (reg_addr == `BCM_ADDR_POSITION)
        reg_rdata_ff <= {1'b0, ring_cnt_ff};
      else if (reg_addr == `BCM_ADDR_CAP)
        reg_rdata_ff <= advance_cap_ff;
      else
        reg_rdata_ff <= `BCM_RST_BYTE;
    end
  end

  // Pins are asynchronous; stage 0 feeds only stage 1, edges use stages 1 and 2
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_sync_ff <= 3'h0;
      b_sync_ff <= 3'h0;
      idx_sync_ff <= 3'h0;
    end
    else
    begin
      a_sync_ff <= {a_sync_ff[1:0], enc_a};
      b_sync_ff <= {b_sync_ff[1:0], enc_b};
      idx_sync_ff <= {idx_sync_ff[1:0], enc_index};
    end
  end

  // Edges wait until stage 2 holds a real pin sample; a pin left high through reset
  // would otherwise look like an edge and give a false count
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      settle_ff <= 3'h0;
    else
      settle_ff <= {settle_ff[1:0], 1'b1};
  end

  assign a_now = a_sync_ff[1];
  assign b_now = b_sync_ff[1];
  assign a_old = a_sync_ff[2];
  assign b_old = b_sync_ff[2];
  // A double transition is a missed count and is dropped rather than guessed
  assign q_step = settle_ff[2] & ((a_now ^ a_old) ^ (b_now ^ b_old));
  assign q_up = ~(a_old ^ b_now);
  // One full count per bar and space: the A edge while B is low
  assign full_step = q_step & ~b_now & ~b_old;
  assign unit_step = full_count ? full_step : q_step;
  assign index_rise = settle_ff[2] & idx_sync_ff[1] & ~idx_sync_ff[2];

  // Position feedback stays in quadrature counts whatever the unit bit says
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quad_step_ff <= 1'b0;
      quad_up_ff <= 1'b0;
    end
    else
    begin
      quad_step_ff <= q_step;
      quad_up_ff <= q_up;
    end
  end

  always @*
  begin
    nxt_ring_cnt = ring_cnt_ff;
    if (hold_commutator)
      nxt_ring_cnt = ring_cnt_ff;
    else if (index_rise)
      nxt_ring_cnt = 7'h00;
    else if (unit_step)
    begin
      if (q_up)
        nxt_ring_cnt = (ring_cnt_ff + 7'h01 >= ring) ? 7'h00 : ring_cnt_ff + 7'h01;
      else
        nxt_ring_cnt = (ring_cnt_ff == 7'h00 || ring_cnt_ff >= ring) ?
          ((ring == 7'h00) ? 7'h00 : ring - 7'h01) : ring_cnt_ff - 7'h01;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ring_cnt_ff <= 7'h00;
    else
      ring_cnt_ff <= nxt_ring_cnt;
  end

  // Speed window of 16 clocks per timer step; held counters see no motion
  assign win_end = (presc_ff == `BCM_PRESCALE_LAST) && (win_tmr_ff == advance_rate_timer_ff);

  always @*
  begin
    nxt_win_cnt = win_cnt_ff;
    if (unit_step && !hold_commutator)
    begin
      if (q_up && win_cnt_ff != 9'h0FF)
        nxt_win_cnt = win_cnt_ff + 9'h001;
      else if (!q_up && win_cnt_ff != 9'h101)
        nxt_win_cnt = win_cnt_ff - 9'h001;
    end
    adv_mag = win_cnt_ff[8] ? 8'h00 - win_cnt_ff[7:0] : win_cnt_ff[7:0];
    if (adv_mag > advance_cap_ff)
      adv_mag = advance_cap_ff;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_ff <= 4'h0;
      win_tmr_ff <= 8'h00;
      win_cnt_ff <= 9'h000;
      advance_ff <= 10'h000;
    end
    else
    begin
      presc_ff <= presc_ff + 4'h1;
      if (presc_ff == `BCM_PRESCALE_LAST)
        win_tmr_ff <= win_end ? 8'h00 : win_tmr_ff + 8'h01;
      if (win_end)
      begin
        win_cnt_ff <= 9'h000;
        advance_ff <= win_cnt_ff[8] ? 10'h000 - {2'b00, adv_mag} : {2'b00, adv_mag};
      end
      else
        win_cnt_ff <= nxt_win_cnt;
    end
  end

  // Shifted, advanced position folded back onto the ring, then split into segments
  always @*
  begin
    ring10 = {3'b000, ring};
    pos = {3'b000, ring_cnt_ff} + {{2{cycle_shift_ff[7]}}, cycle_shift_ff} + advance_ff;
    if (pos[9])
      pos = pos + ring10;
    if (pos[9])
      pos = pos + ring10;
    if (!pos[9] && pos >= ring10)
      pos = pos - ring10;
    if (!pos[9] && pos >= ring10)
      pos = pos - ring10;
    if (ring == 7'h00 || pos[9])
      pos = 10'h000;
    step10 = {2'b00, lone_phase_span_ff} + {2'b00, overlap_span_ff};
    if (step10 == 10'h000 || pos < step10)
      seg = 2'd0;
    else if (pos < (step10 << 1))
      seg = 2'd1;
    else if (!four_phase || pos < (step10 << 1) + step10)
      seg = 2'd2;
    else
      seg = 2'd3;
    rem = pos - step10 * {8'h00, seg};
    ovl = (rem >= {2'b00, lone_phase_span_ff}) && (overlap_span_ff != 8'h00);
    if ((seg == 2'd2 && !four_phase) || seg == 2'd3)
      seg_next = 2'd0;
    else
      seg_next = seg + 2'd1;
    nxt_phase = 4'h0;
    nxt_phase[seg] = 1'b1;
    if (ovl)
      nxt_phase[seg_next] = 1'b1;
  end

  // Registered enables; sequencing only, the drive level is combined outside
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_winding_drive <= 1'b0;
      second_winding_drive <= 1'b0;
      third_winding_drive <= 1'b0;
      fourth_winding_drive <= 1'b0;
    end
    else
    begin
      first_winding_drive <= nxt_phase[0];
      second_winding_drive <= nxt_phase[1];
      third_winding_drive <= nxt_phase[2];
      fourth_winding_drive <= nxt_phase[3] & four_phase;
    end
  end

endmodule // bcm_commutator
`default_nettype wire

// File: testbench/bcm_encoder_model.sv
/*
 Three-channel incremental encoder model driving A, B and index for the commutator.
 Assumes the bench requests one step at a time and spaces requests by several cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module bcm_encoder_model
(
  input wire logic mclk,
  input wire logic step_req,
  input wire logic step_up,
  input wire logic index_req,
  output logic enc_a,
  output logic enc_b,
  output logic enc_index
);
  logic [1:0] pos_ff = 2'h0;
  initial enc_index = 1'b0;
  always @(posedge mclk)
  begin
    if (step_req)
      pos_ff <= step_up ? pos_ff + 2'h1 : pos_ff - 2'h1;
    enc_index <= index_req;
  end
  // Gray order 00,10,11,01 so A leads B when counting up; one pin changes per step
  assign enc_a = pos_ff[1] ^ pos_ff[0];
  assign enc_b = pos_ff[1];
endmodule // bcm_encoder_model
`default_nettype wire

// File: testbench/bcm_commutator_sva.sv
/*
 Port checker for the commutator: register bus, encoder step and phase output relations.
 Assumes a bind from the bench top and a single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module bcm_commutator_sva
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic quad_step_ff,
  input wire logic first_winding_drive,
  input wire logic second_winding_drive,
  input wire logic third_winding_drive,
  input wire logic fourth_winding_drive
);
  logic four_ff;
  wire logic [3:0] ph = {fourth_winding_drive, third_winding_drive, second_winding_drive, first_winding_drive};
  // Shadow of the phase count bit, seen only through host writes
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
      four_ff <= 1'b0;
    else if (reg_wr && reg_addr == 8'h07)
      four_ff <= reg_wdata[1];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_shift; reg_wr && reg_addr == 8'h1C; endsequence
  sequence s_wr_ring; reg_wr && reg_addr == 8'h18; endsequence
  chk_phase_count: assert property ($past(rst_n) |-> $countones(ph) inside {1, 2})
    else $error("phase count out of range");
  chk_overlap_pair: assert property ($countones(ph) == 2 |-> ph inside {4'h3, 4'h6, 4'hC, 4'h9, 4'h5})
    else $error("overlap phases not adjacent");
  chk_fourth_idle: assert property (!four_ff && !$past(four_ff) && !$past(four_ff, 2) |-> !fourth_winding_drive)
    else $error("fourth phase active in three phase mode");
  chk_step_pulse: assert property (quad_step_ff |=> !quad_step_ff)
    else $error("step pulse longer than one cycle");
  chk_step_latency: assert property ($changed(enc_a) || $changed(enc_b) |-> ##[1:4] quad_step_ff)
    else $error("encoder edge not counted");
  chk_rdata_stands: assert property (!$past(reg_rd) |-> $stable(reg_rdata_ff))
    else $error("read data changed without read");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h00, 8'h07, 8'h18, 8'h19, 8'h1A,
    8'h1B, 8'h1C, 8'h1E, 8'h1F}) |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  chk_shift_readback: assert property (s_wr_shift ##1 (reg_rd && reg_addr == 8'h1C)
    |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("shift readback wrong");
  chk_ring_mask: assert property (s_wr_ring ##1 (reg_rd && reg_addr == 8'h18)
    |=> reg_rdata_ff == ($past(reg_wdata, 2) & 8'h7F))
    else $error("ring readback not masked");
endmodule // bcm_commutator_sva
`default_nettype wire

// File: testbench/test_brushless_commutator.sv
/*
 Self-checking bench for the commutator with a behavioural ring counter model.
 Assumes the encoder model and checker are compiled first; advance left at zero.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, got, exp); end end
module test_brushless_commutator;
  logic mclk = 1'b0, rst_n = 1'b0, step_req = 1'b0, step_up = 1'b0, index_req = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
  logic [31:0] seed = 32'h6C9741CD, r;
  wire logic enc_a, enc_b, enc_index, quad_step_ff, quad_up_ff, ph1, ph2, ph3, ph4;
  wire logic [7:0] reg_rdata_ff;
  wire logic [3:0] ph = {ph4, ph3, ph2, ph1};
  int err_total = 0, check_count = 0, cnt = 0, ring = 0, lone = 0, ovl = 0, shift = 0, nph = 3, held = 0;
  int full = 0, epos = 0;
  bcm_encoder_model bcm_encoder_model_inst (.mclk(mclk), .step_req(step_req), .step_up(step_up),
    .index_req(index_req), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));
  bcm_commutator bcm_commutator_inst (.mclk(mclk), .rst_n(rst_n), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .quad_step_ff(quad_step_ff), .quad_up_ff(quad_up_ff),
    .first_winding_drive(ph1), .second_winding_drive(ph2), .third_winding_drive(ph3),
    .fourth_winding_drive(ph4));
  initial forever #10 mclk = ~mclk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Reference phase pattern for a ring position; advance is zero here
  function automatic logic [3:0] exp_ph(int c);
    int p, st, seg;
    st = lone + ovl;
    if (ring == 0 || st == 0)
      return 4'h1;
    p = (c + shift) % ring;
    seg = p / st;
    if (seg > nph - 1)
      seg = nph - 1;
    exp_ph = 4'h1 << seg;
    if (ovl != 0 && p - seg * st >= lone)
      exp_ph = exp_ph | (4'h1 << ((seg + 1) % nph));
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  // Write then read back on the next edge; each strobe is set and cleared once
  task automatic wr_rd(logic [7:0] a, logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    rdata = reg_rdata_ff;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    rdata = reg_rdata_ff;
    tick(1);
  endtask
  task automatic step(logic up);
    int n;
    step_req = 1'b1;
    step_up = up;
    tick(1);
    step_req = 1'b0;
    n = 0;
    while (quad_step_ff !== 1'b1 && n < 8)
    begin
      tick(1);
      n++;
    end
    `CHK(quad_step_ff, 1'b1)
    `CHK(quad_up_ff, up)
    // Full counts move only on the A edge while B is low: encoder states 0 and 1
    if (held == 0 && (full == 0 || (up ? epos == 0 : epos == 1)))
      cnt = up ? (cnt + 1) % ring : (cnt + ring - 1) % ring;
    epos = up ? (epos + 1) % 4 : (epos + 3) % 4;
    tick(2);
    `CHK(ph, exp_ph(cnt))
  endtask
  task automatic summarize();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    summarize();
  end
  initial
  begin
    tick(6);
    rst_n = 1'b1;
    tick(2);
    `CHK(ph, 4'h1)
    wr_rd(8'h1C, 8'h03);
    `CHK(rdata, 8'h03)
    wr(8'h1A, 8'h03);
    wr_rd(8'h18, 8'hFF);
    `CHK(rdata, 8'h7F)
    rd(8'h05);
    `CHK(rdata, 8'h00)
    // Spans go in before the ring so the step length is never zero
    wr(8'h00, 8'h10);
    wr(8'h07, 8'h00);
    wr(8'h18, 8'h09);
    held = 1;
    ring = 9;
    lone = 3;
    for (int s = 0; s < 9; s++)
    begin
      wr(8'h1C, s[7:0]);
      shift = s;
      tick(2);
      `CHK(ph, 4'h1 << (s / 3))
    end
    step(1'b1);
    wr(8'h00, 8'h00);
    held = 0;
    wr(8'h07, 8'h02);
    nph = 4;
    wr(8'h1A, 8'h01);
    wr(8'h1B, 8'h01);
    wr(8'h18, 8'h08);
    wr(8'h1C, 8'h02);
    lone = 1;
    ovl = 1;
    ring = 8;
    shift = 2;
    repeat (40)
    begin
      r = xs();
      step(r[0]);
    end
    // The index must find the counter away from zero or its check proves nothing
    if (cnt == 0)
      step(1'b1);
    rd(8'h1E);
    `CHK(rdata, cnt[7:0])
    index_req = 1'b1;
    tick(3);
    index_req = 1'b0;
    tick(4);
    cnt = 0;
    `CHK(ph, exp_ph(0))
    rd(8'h1E);
    `CHK(rdata, 8'h00)
    wr(8'h07, 8'h06);
    full = 1;
    repeat (24)
    begin
      r = xs();
      step(r[0]);
    end
    rd(8'h1E);
    `CHK(rdata, cnt[7:0])
    rst_n = 1'b0;
    tick(2);
    `CHK(ph, 4'h0)
    rst_n = 1'b1;
    tick(2);
    `CHK(ph, 4'h1)
    summarize();
  end
endmodule // test_brushless_commutator
bind bcm_commutator bcm_commutator_sva bcm_commutator_sva_inst (.mclk(mclk), .rst_n(rst_n), .enc_a(enc_a),
  .enc_b(enc_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .quad_step_ff(quad_step_ff), .first_winding_drive(first_winding_drive),
  .second_winding_drive(second_winding_drive), .third_winding_drive(third_winding_drive),
  .fourth_winding_drive(fourth_winding_drive));
`default_nettype wire
